// file: cpc_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cpc_chan_if;
   logic [15:0] q_word;
   logic        write_strobe;
   logic        read_strobe;
   logic [15:0] host_a;
   logic        host_a_oe_n;
   logic [15:0] dev_a;
   logic        dev_a_oe_n;
   logic        reply;
   logic        reject;
   logic [15:0] irq_lines;
   logic [15:0] a_bus;

   // ==========================================================
   // Resolved level of the two-way data lines
   assign a_bus = !host_a_oe_n ? host_a : (!dev_a_oe_n ? dev_a : 16'h0000);

   modport host (output q_word, write_strobe, read_strobe, host_a, host_a_oe_n,
                 input a_bus, reply, reject, irq_lines);
   modport dev  (input q_word, write_strobe, read_strobe, a_bus,
                 output dev_a, dev_a_oe_n, reply, reject, irq_lines);
endinterface : cpc_chan_if
`default_nettype wire

// file: cpc_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cpc_chk #(
   parameter logic [3:0] EQUIP_CODE = 4'h2,
   parameter int         INT_LINE   = 0
) (
   input wire logic        core_clk_in,  // Clock
   input wire logic        reset_in,     // Sync reset, high
   input wire logic [15:0] q_word,       // Function word
   input wire logic        write_strobe, // Host write pulse
   input wire logic        read_strobe,  // Host read pulse
   input wire logic        host_a_oe_n,  // Host drives lines, low
   input wire logic        dev_a_oe_n,   // Device drives lines, low
   input wire logic        reply,        // Device reply
   input wire logic        reject,       // Device reject
   input wire logic [15:0] irq_lines,    // Interrupt lines
   input wire logic [15:0] a_bus         // Resolved data lines
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   // ==========================================================
   // Station and equipment match
   logic sel;
   logic strb;
   assign sel  = q_word[6] && !q_word[5] && q_word[10:7] == EQUIP_CODE && q_word[15:11] == 5'h00;
   assign strb = write_strobe || read_strobe;
   // ==========================================================
   // Properties
   property p_answer; strb && sel |=> reply != reject; endproperty
   property p_silent; strb && !sel |=> !reply && !reject; endproperty
   property p_no_stray; reply || reject |-> $past(strb); endproperty
   property p_strobe_pulse; strb |=> !strb ##1 !strb; endproperty
   property p_host_drive; !host_a_oe_n |-> write_strobe; endproperty
   property p_dev_drive; !dev_a_oe_n |-> reply && $past(read_strobe); endproperty
   property p_stat_zero; !dev_a_oe_n |-> a_bus[15:9] == 7'h00 && !a_bus[6]; endproperty
   property p_done_excl;
      !dev_a_oe_n |-> !(a_bus[cpc_pkg::S_DONE] && (a_bus[cpc_pkg::S_BUSY] || a_bus[cpc_pkg::S_DATA]));
   endproperty
   property p_irq_line; (irq_lines & ~(16'h0001 << INT_LINE)) == 16'h0000; endproperty
   a_answer: assert property (p_answer) else $error("selected strobe not answered once");
   a_silent: assert property (p_silent) else $error("answer to other station");
   a_no_stray: assert property (p_no_stray) else $error("answer without strobe");
   a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe not single");
   a_host_drive: assert property (p_host_drive) else $error("host drives outside write");
   a_dev_drive: assert property (p_dev_drive) else $error("device drives outside read reply");
   a_stat_zero: assert property (p_stat_zero) else $error("unused status bits set");
   a_done_excl: assert property (p_done_excl) else $error("card done with busy or data");
   a_irq_line: assert property (p_irq_line) else $error("interrupt on wrong line");
   c_punch: cover property (write_strobe && q_word[1:0] == 2'b00 ##1 reply);
   c_reject: cover property (write_strobe ##1 reject);
   c_irq: cover property (irq_lines != 16'h0000);
endmodule : cpc_chk
`default_nettype wire

// file: cpc_dev.sv
// How it works
// [RQ1] 16-bit word, low 12 bits one column
// [RQ2] Function word gives station, equipment, director
// [RQ3] Clear controller resets all; data follows ready
// [RQ4] Column transfer only while data status set
// [RQ5] Transfer drops data, sets busy, punches
// [RQ6] Busy from first column to card end
// [RQ7] Column done sets data unless last
// [RQ8] Column 80: end flag, busy off, wait
// [RQ9] Feed stacks card, brings new card
// [RQ10] Feed accepted only ready, online, uninhibited
// [RQ11] Accepted feed clears error and alarm
// [RQ12] Punch error sets error, alarm; continue
// [RQ13] Not ready during card: alarm, end, idle
// [RQ14] Early feed suppresses end flag
// [RQ15] Host should await status before feed
// [RQ16] Offset applies to card leaving station
// [RQ17] Interrupts go to one chosen line
// [RQ18] Respond only to station bits 0,1
// [RQ19] Director 00 punch, 01 director write
// [RQ20] Data bits 0-11 drive rows, 11 top
// [RQ21] Column counter cleared by feed/clear
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cpc_dev #(
   parameter int         COLS       = cpc_pkg::COLS_PER_CARD,
   parameter logic [3:0] EQUIP_CODE = 4'h2,
   parameter int         INT_LINE   = 0
) (
   input  wire logic        core_clk_in,      // Clock
   input  wire logic        reset_in,         // Sync reset, high
   cpc_chan_if.dev          ch,               // Channel from host
   input  wire logic        punch_ready_in,   // Punch ready
   input  wire logic        punch_online_in,  // Punch on line
   input  wire logic        punch_inhibit_in, // Punch inhibit mode
   input  wire logic        column_done_in,   // Column finished, rising edge
   input  wire logic        punch_error_in,   // Error on finished column
   input  wire logic        feed_ack_in,      // Feed cycle started
   input  wire logic        protect_in,       // Protect switch
   output logic      [11:0] punch_rows_out,   // Row pattern, bit 11 top row
   output logic             punch_strobe_out, // Punch column pulse
   output logic             feed_out,         // Feed pulse
   output logic             offset_out        // Offset level
);
   localparam int CNT_W = $clog2(COLS + 1);

   typedef struct packed {
      logic [cpc_pkg::PIN_N-1:0] s1;
      logic [cpc_pkg::PIN_N-1:0] s2;
      logic [cpc_pkg::PIN_N-1:0] s3;
      logic [cpc_pkg::PIN_N-1:0] filt;
      logic [CNT_W-1:0]          cnt;
      logic                      data;
      logic                      busy;
      logic                      card_done_flag;
      logic                      alarm;
      logic                      error;
      logic                      in_flight;
      logic                      stop;
      logic                      feed_wait;
      logic                      offset;
      logic                      feed;
      logic                      strobe;
      logic [2:0]                int_req;
      logic [2:0]                int_resp;
      logic [11:0]               rows;
      logic [15:0]               a;
      logic                      a_oe_n;
      logic                      reply;
      logic                      reject;
      logic                      irq;
   } cpc_dev_s;

   cpc_dev_s                  st;
   cpc_dev_s                  next_st;
   logic [cpc_pkg::PIN_N-1:0] pins;
   logic                      sel;
   logic [1:0]                dir;
   logic [15:0]               aw;
   logic                      on_ok;
   logic                      feed_ok;
   logic                      bad;
   logic                      col_rise;
   logic                      ack_rise;
   logic [15:0]               stat1;

   // ==========================================================
   // Next state
   always_comb begin
      next_st = st;
      pins = {protect_in, feed_ack_in, punch_error_in, column_done_in,
              punch_inhibit_in, punch_online_in, punch_ready_in};
      next_st.s1 = pins;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      for (int i = 0; i < cpc_pkg::PIN_N; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            next_st.filt[i] = st.s3[i];
         end
      end
      col_rise = next_st.filt[cpc_pkg::P_COLDONE] & ~st.filt[cpc_pkg::P_COLDONE];
      ack_rise = next_st.filt[cpc_pkg::P_FEEDACK] & ~st.filt[cpc_pkg::P_FEEDACK];
      on_ok = st.filt[cpc_pkg::P_READY] & st.filt[cpc_pkg::P_ONLINE];
      feed_ok = on_ok & ~st.filt[cpc_pkg::P_INHIBIT];
      aw = ch.a_bus;
      dir = {ch.q_word[cpc_pkg::Q_DIR1], ch.q_word[cpc_pkg::Q_DIR0]}; // RQ2
      sel = ~ch.q_word[cpc_pkg::Q_ST5] & ch.q_word[cpc_pkg::Q_ST6] & // RQ18
            (ch.q_word[cpc_pkg::Q_EQ_HI:cpc_pkg::Q_EQ_LO] == EQUIP_CODE) &
            (ch.q_word[15:cpc_pkg::Q_W_LO] == 5'h00);
      bad = ((|aw[cpc_pkg::D_OFFSET:cpc_pkg::D_INT_DATA]) & ~on_ok) | // RQ10
            (aw[cpc_pkg::D_FEED] & ~feed_ok);
      stat1 = 16'h0000;
      stat1[cpc_pkg::S_READY] = on_ok;
      stat1[cpc_pkg::S_BUSY] = st.busy;
      stat1[cpc_pkg::S_INT] = st.irq;
      stat1[cpc_pkg::S_DATA] = st.data;
      stat1[cpc_pkg::S_DONE] = st.card_done_flag;
      stat1[cpc_pkg::S_ALARM] = st.alarm;
      stat1[cpc_pkg::S_PROTECT] = st.filt[cpc_pkg::P_PROTECT];
      stat1[cpc_pkg::S_ERROR] = st.error;
      next_st.reply = 1'h0;
      next_st.reject = 1'h0;
      next_st.strobe = 1'h0;
      next_st.feed = 1'h0;
      next_st.a_oe_n = 1'h1;
      next_st.a = 16'h0000;

      // ==========================================================
      // Host requests; clears act before hardware events below
      if (sel & ch.write_strobe) begin
         unique case (dir) // RQ19
            2'h0: begin
               if (st.data) begin // RQ4
                  next_st.data = 1'h0; // RQ5
                  next_st.busy = 1'h1; // RQ6
                  next_st.in_flight = 1'h1;
                  next_st.rows = aw[cpc_pkg::COL_W-1:0]; // RQ1 RQ20
                  next_st.strobe = 1'h1;
                  next_st.int_resp[0] = 1'h0;
                  next_st.reply = 1'h1;
               end else begin
                  next_st.reject = 1'h1;
               end
            end
            2'h1: begin
               if (bad) begin
                  next_st.reject = 1'h1;
               end else begin
                  next_st.reply = 1'h1;
                  if (aw[cpc_pkg::D_CLR_CTRL]) begin // RQ3
                     next_st.cnt = '0; // RQ21
                     next_st.data = feed_ok;
                     next_st.busy = 1'h0;
                     next_st.card_done_flag = 1'h0;
                     next_st.alarm = 1'h0;
                     next_st.error = 1'h0;
                     next_st.in_flight = 1'h0;
                     next_st.stop = 1'h0;
                     next_st.feed_wait = 1'h0;
                     next_st.offset = 1'h0;
                     next_st.int_req = 3'h0;
                     next_st.int_resp = 3'h0;
                  end
                  if (aw[cpc_pkg::D_CLR_INT]) begin
                     next_st.int_req = 3'h0;
                     next_st.int_resp = 3'h0;
                  end
                  next_st.int_req = next_st.int_req | aw[cpc_pkg::D_INT_ALARM:cpc_pkg::D_INT_DATA];
                  if (aw[cpc_pkg::D_FEED]) begin
                     next_st.feed = 1'h1; // RQ9
                     next_st.feed_wait = 1'h1;
                     next_st.error = 1'h0; // RQ11
                     next_st.alarm = 1'h0;
                     next_st.card_done_flag = 1'h0;
                     next_st.cnt = '0; // RQ21
                     next_st.data = 1'h0;
                     // A column still in the punch ends the card without the end flag
                     next_st.stop = st.in_flight; // RQ14
                     next_st.busy = st.in_flight;
                  end
                  if (aw[cpc_pkg::D_OFFSET]) begin
                     next_st.offset = 1'h1; // RQ16
                  end
               end
            end
            default: next_st.reject = 1'h1;
         endcase
      end else if (sel & ch.read_strobe) begin
         unique case (dir)
            2'h1: begin
               next_st.a = stat1;
               next_st.a_oe_n = 1'h0;
               next_st.reply = 1'h1;
            end
            2'h3: begin
               next_st.a = 16'h0000;
               next_st.a_oe_n = 1'h0;
               next_st.reply = 1'h1;
            end
            default: next_st.reject = 1'h1;
         endcase
      end

      // ==========================================================
      // Punch events; sets here win over clears above
      if (col_rise & next_st.in_flight) begin
         next_st.in_flight = 1'h0;
         if (next_st.filt[cpc_pkg::P_ERR]) begin
            next_st.error = 1'h1; // RQ12
            next_st.alarm = 1'h1;
         end
         if (next_st.stop) begin
            next_st.stop = 1'h0;
            next_st.busy = 1'h0; // RQ14
            next_st.data = ~next_st.feed_wait & feed_ok;
         end else if (next_st.cnt + CNT_W'(1) == CNT_W'(COLS)) begin
            next_st.cnt = CNT_W'(COLS); // RQ21
            next_st.card_done_flag = 1'h1; // RQ8
            next_st.busy = 1'h0; // RQ6 RQ8
         end else begin
            next_st.cnt = next_st.cnt + CNT_W'(1); // RQ21
            next_st.data = 1'h1; // RQ7
         end
      end
      if (ack_rise) begin
         next_st.feed_wait = 1'h0;
         next_st.offset = 1'h0; // RQ16
         next_st.data = feed_ok & ~next_st.in_flight;
      end
      if (~feed_ok) begin
         next_st.data = 1'h0;
         if (next_st.busy) begin
            next_st.alarm = 1'h1; // RQ13
            next_st.card_done_flag = 1'h1;
            next_st.busy = 1'h0;
            next_st.in_flight = 1'h0;
            next_st.stop = 1'h0;
         end
      end

      // ==========================================================
      // Interrupt responses
      next_st.int_resp = next_st.int_resp | (next_st.int_req &
                         {next_st.alarm, next_st.card_done_flag, next_st.data});
      next_st.irq = |next_st.int_resp; // RQ17
   end

   // ==========================================================
   // State register
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         st <= '0;
         st.a_oe_n <= 1'h1;
      end else begin
         st <= next_st;
      end
   end

   assign punch_rows_out   = st.rows;
   assign punch_strobe_out = st.strobe;
   assign feed_out         = st.feed;
   assign offset_out       = st.offset;
   assign ch.dev_a         = st.a;
   assign ch.dev_a_oe_n    = st.a_oe_n;
   assign ch.reply         = st.reply;
   assign ch.reject        = st.reject;
   assign ch.irq_lines     = 16'(st.irq) << INT_LINE; // RQ17
endmodule : cpc_dev
`default_nettype wire

// file: cpc_host.sv
`timescale 1ns/1ps
`default_nettype none
module cpc_host (
   input  wire logic        core_clk_in,   // Clock
   input  wire logic        reset_in,      // Sync reset, high
   input  wire logic        psel_in,       // APB select
   input  wire logic        penable_in,    // APB enable
   input  wire logic        pwrite_in,     // APB direction
   input  wire logic [7:0]  paddr_in,      // APB byte address
   input  wire logic [31:0] pwdata_in,     // APB write data
   output logic      [31:0] prdata_out,    // APB read data
   output logic             pready_out,    // APB ready
   output logic             pslverr_out,   // APB error
   cpc_chan_if.host         ch             // Channel to controller
);
   typedef enum logic [0:0] {HS_IDLE, HS_WAIT} cpc_hst_e;

   typedef struct packed {
      cpc_hst_e    state;
      logic [15:0] func;
      logic [15:0] data;
      logic [15:0] rdata;
      logic [15:0] q;
      logic [15:0] a;
      logic        a_oe_n;
      logic        wstb;
      logic        rstb;
      logic        is_read;
      logic        got_reply;
      logic        got_reject;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } cpc_host_s;

   cpc_host_s st;
   cpc_host_s next_st;
   logic      wr_now;
   logic      pend;

   // ==========================================================
   // Next state
   always_comb begin
      next_st = st;
      pend = (st.state == HS_WAIT);
      wr_now = psel_in & penable_in & st.pready & pwrite_in;
      next_st.wstb = 1'h0;
      next_st.rstb = 1'h0;
      next_st.a_oe_n = 1'h1;
      // Zero-wait answer: pready rises in the first access cycle
      next_st.pready = psel_in & ~penable_in;
      next_st.pslverr = 1'h0;
      next_st.prdata = 32'h00000000;
      if (psel_in & ~penable_in) begin
         unique case (paddr_in)
            cpc_pkg::REG_FUNC: next_st.prdata = {16'h0000, st.func};
            cpc_pkg::REG_DATA: next_st.prdata = {16'h0000, st.rdata};
            cpc_pkg::REG_GO:   next_st.prdata = 32'h00000000;
            cpc_pkg::REG_STAT: begin
               // Software polls the pending flag through here until the device replies or rejects
               next_st.prdata[cpc_pkg::ST_PEND] = pend; // RQ15
               next_st.prdata[cpc_pkg::ST_REPLY] = st.got_reply;
               next_st.prdata[cpc_pkg::ST_REJECT] = st.got_reject;
               next_st.prdata[cpc_pkg::ST_IRQ] = |ch.irq_lines;
            end
            default: next_st.pslverr = ~pwrite_in;
         endcase
         if (pwrite_in && paddr_in != cpc_pkg::REG_FUNC && paddr_in != cpc_pkg::REG_DATA &&
             paddr_in != cpc_pkg::REG_GO && paddr_in != cpc_pkg::REG_STAT) begin
            next_st.pslverr = 1'h1;
         end
      end
      if (wr_now && paddr_in == cpc_pkg::REG_FUNC) begin
         next_st.func = pwdata_in[15:0]; // RQ2
      end
      if (wr_now && paddr_in == cpc_pkg::REG_DATA) begin
         next_st.data = pwdata_in[15:0]; // RQ1
      end
      unique case (st.state)
         HS_IDLE: begin
            if (wr_now && paddr_in == cpc_pkg::REG_GO &&
                (pwdata_in[cpc_pkg::GO_WRITE] | pwdata_in[cpc_pkg::GO_READ])) begin
               next_st.is_read = pwdata_in[cpc_pkg::GO_READ];
               next_st.q = st.func; // RQ18 RQ19
               next_st.a = st.data;
               next_st.a_oe_n = pwdata_in[cpc_pkg::GO_READ];
               next_st.wstb = ~pwdata_in[cpc_pkg::GO_READ];
               next_st.rstb = pwdata_in[cpc_pkg::GO_READ];
               next_st.got_reply = 1'h0;
               next_st.got_reject = 1'h0;
               next_st.state = HS_WAIT;
            end
         end
         HS_WAIT: begin
            if (ch.reply) begin
               next_st.got_reply = 1'h1;
               if (st.is_read) begin
                  next_st.rdata = ch.a_bus;
               end
               next_st.state = HS_IDLE;
            end else if (ch.reject) begin
               next_st.got_reject = 1'h1;
               next_st.state = HS_IDLE;
            end
         end
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         st <= '0;
         st.a_oe_n <= 1'h1;
      end else begin
         st <= next_st;
      end
   end

   assign prdata_out      = st.prdata;
   assign pready_out      = st.pready;
   assign pslverr_out     = st.pslverr;
   assign ch.q_word       = st.q;
   assign ch.write_strobe = st.wstb;
   assign ch.read_strobe  = st.rstb;
   assign ch.host_a       = st.a;
   assign ch.host_a_oe_n  = st.a_oe_n;
endmodule : cpc_host
`default_nettype wire

// file: cpc_pkg.sv
`default_nettype none
package cpc_pkg;
   // ==========================================================
   // Channel word layout
   localparam int WORD_W        = 16;
   localparam int COL_W         = 12;
   localparam int COLS_PER_CARD = 80;
   localparam int Q_DIR0        = 0;
   localparam int Q_DIR1        = 1;
   localparam int Q_ST5         = 5;
   localparam int Q_ST6         = 6;
   localparam int Q_EQ_LO       = 7;
   localparam int Q_EQ_HI       = 10;
   localparam int Q_W_LO        = 11;
   // ==========================================================
   // Director function bits
   localparam int D_CLR_CTRL  = 0;
   localparam int D_CLR_INT   = 1;
   localparam int D_INT_DATA  = 2;
   localparam int D_INT_DONE  = 3;
   localparam int D_INT_ALARM = 4;
   localparam int D_FEED      = 7;
   localparam int D_OFFSET    = 8;
   // ==========================================================
   // Status 1 bits
   localparam int S_READY   = 0;
   localparam int S_BUSY    = 1;
   localparam int S_INT     = 2;
   localparam int S_DATA    = 3;
   localparam int S_DONE    = 4;
   localparam int S_ALARM   = 5;
   localparam int S_PROTECT = 7;
   localparam int S_ERROR   = 8;
   // ==========================================================
   // Punch pin indexes
   localparam int P_READY   = 0;
   localparam int P_ONLINE  = 1;
   localparam int P_INHIBIT = 2;
   localparam int P_COLDONE = 3;
   localparam int P_ERR     = 4;
   localparam int P_FEEDACK = 5;
   localparam int P_PROTECT = 6;
   localparam int PIN_N     = 7;
   // ==========================================================
   // Host register map
   localparam logic [7:0] REG_FUNC = 8'h00;
   localparam logic [7:0] REG_DATA = 8'h04;
   localparam logic [7:0] REG_GO   = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0c;
   localparam int GO_WRITE  = 0;
   localparam int GO_READ   = 1;
   localparam int ST_PEND   = 0;
   localparam int ST_REPLY  = 1;
   localparam int ST_REJECT = 2;
   localparam int ST_IRQ    = 3;
endpackage : cpc_pkg
`default_nettype wire

// file: tb_card_punch_column_controller.sv
`timescale 1ns/1ps
`default_nettype none
module tb_card_punch_column_controller;
   localparam int          COLS = 4;
   localparam logic [3:0]  EQ   = 4'h2;
   localparam int          IL   = 5;
   localparam logic [31:0] RPL  = 32'h2;
   localparam logic [31:0] REJ  = 32'h4;
   localparam logic [31:0] RDY  = 32'h1 << cpc_pkg::S_READY;
   localparam logic [31:0] BSY  = 32'h1 << cpc_pkg::S_BUSY;
   localparam logic [31:0] DAT  = 32'h1 << cpc_pkg::S_DATA;
   localparam logic [31:0] CDN  = 32'h1 << cpc_pkg::S_DONE;
   localparam logic [31:0] ALM  = 32'h1 << cpc_pkg::S_ALARM;
   localparam logic [31:0] ERR  = 32'h1 << cpc_pkg::S_ERROR;
   logic        core_clk_in, reset_in, psel, penable, pwrite, pready, pslverr, err_seen;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rsp, rdv;
   logic        p_rdy, p_onl, p_inh, p_col, p_err, p_fack;
   logic [11:0] rows;
   logic        strobe, feed, offset;
   int          n_fail, checked, n_strobe, n_feed, i;
   cpc_chan_if ch ();
   cpc_host cpc_host_i (.core_clk_in(core_clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .ch(ch));
   cpc_dev #(.COLS(COLS), .EQUIP_CODE(EQ), .INT_LINE(IL)) cpc_dev_i (.core_clk_in(core_clk_in),
      .reset_in(reset_in), .ch(ch), .punch_ready_in(p_rdy), .punch_online_in(p_onl), .punch_inhibit_in(p_inh),
      .column_done_in(p_col), .punch_error_in(p_err), .feed_ack_in(p_fack), .protect_in(1'b0),
      .punch_rows_out(rows), .punch_strobe_out(strobe), .feed_out(feed), .offset_out(offset));
   cpc_chk #(.EQUIP_CODE(EQ), .INT_LINE(IL)) cpc_chk_i (.core_clk_in(core_clk_in), .reset_in(reset_in),
      .q_word(ch.q_word), .write_strobe(ch.write_strobe), .read_strobe(ch.read_strobe),
      .host_a_oe_n(ch.host_a_oe_n), .dev_a_oe_n(ch.dev_a_oe_n), .reply(ch.reply), .reject(ch.reject),
      .irq_lines(ch.irq_lines), .a_bus(ch.a_bus));
   initial begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end
   always @(posedge core_clk_in) begin
      n_strobe <= n_strobe + int'(strobe === 1'b1);
      n_feed   <= n_feed + int'(feed === 1'b1);
   end
   // ==========================================================
   // Access tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge core_clk_in);
      penable <= 1'b1;
      do @(posedge core_clk_in); while (pready !== 1'b1);
      r = prdata;
      err_seen = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk_in);
   endtask : apb
   function automatic logic [15:0] qw(input logic [1:0] dir);
      return {5'h00, EQ, 2'b10, 3'h0, dir};
   endfunction : qw
   task automatic chan(input logic [15:0] q, input logic [15:0] a, input logic rd);
      logic [31:0] x;
      int k;
      apb(1'b1, cpc_pkg::REG_FUNC, {16'h0, q}, x);
      apb(1'b1, cpc_pkg::REG_DATA, {16'h0, a}, x);
      apb(1'b1, cpc_pkg::REG_GO, rd ? 32'h2 : 32'h1, x);
      for (k = 0; k < 20; k++) begin
         apb(1'b0, cpc_pkg::REG_STAT, 32'h0, rsp);
         if (rsp[cpc_pkg::ST_PEND] === 1'b0) break;
      end
      apb(1'b0, cpc_pkg::REG_DATA, 32'h0, rdv);
   endtask : chan
   task automatic op(input logic [1:0] dir, input logic [15:0] a, input logic [31:0] exp);
      chan(qw(dir), a, 1'b0);
      chk("answer", rsp & 32'h7, exp);
   endtask : op
   task automatic stat(input string nm, input logic [31:0] exp);
      chan(qw(2'b01), 16'h0000, 1'b1);
      chk(nm, {16'h0, rdv[15:0]}, exp);
   endtask : stat
   task automatic pulse(input logic fa, input logic e);
      p_fack <= fa;
      p_col  <= !fa;
      p_err  <= e;
      repeat (5) @(posedge core_clk_in);
      p_fack <= 1'b0;
      p_col  <= 1'b0;
      p_err  <= 1'b0;
      repeat (5) @(posedge core_clk_in);
   endtask : pulse
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (20000) @(posedge core_clk_in);
      n_fail++;
      finish_test;
   end
   // ==========================================================
   // Tests
   initial begin
      {reset_in, p_rdy, p_onl} <= 3'b111;
      {psel, penable, pwrite, p_inh, p_col, p_err, p_fack} <= 7'h00;
      {paddr, pwdata, n_fail, checked, n_strobe, n_feed} = '0;
      repeat (16) @(posedge core_clk_in);
      reset_in <= 1'b0;
      repeat (8) @(posedge core_clk_in);
      stat("status at reset", RDY);
      op(2'b00, 16'h0fff, REJ);
      op(2'b01, 16'h0001, RPL);
      stat("status at clear", RDY | DAT);
      $display("test clear done");
      op(2'b00, 16'hf5a3, RPL);
      chk("rows", {20'h0, rows}, 32'h5a3);
      stat("first column", RDY | BSY);
      op(2'b00, 16'h0001, REJ);
      pulse(1'b0, 1'b1);
      stat("punch error", RDY | BSY | DAT | ALM | ERR);
      for (i = 1; i < COLS; i++) begin
         op(2'b00, 16'(i), RPL);
         chk("rows", {20'h0, rows}, 32'(i));
         pulse(1'b0, 1'b0);
      end
      stat("card end", RDY | CDN | ALM | ERR);
      chk("strobes", 32'(n_strobe), 32'(COLS));
      $display("test card done");
      op(2'b01, 16'h0180, RPL);
      chk("offset on", {31'h0, offset}, 32'h1);
      chk("feed pulse", 32'(n_feed), 32'h1);
      stat("after feed", RDY);
      pulse(1'b1, 1'b0);
      chk("offset off", {31'h0, offset}, 32'h0);
      stat("new card", RDY | DAT);
      op(2'b00, 16'h0001, RPL);
      pulse(1'b0, 1'b0);
      op(2'b00, 16'h0002, RPL);
      op(2'b01, 16'h0080, RPL);
      pulse(1'b0, 1'b0);
      stat("early feed", RDY);
      pulse(1'b1, 1'b0);
      $display("test feed done");
      p_inh <= 1'b1;
      repeat (8) @(posedge core_clk_in);
      op(2'b01, 16'h0080, REJ);
      p_inh <= 1'b0;
      repeat (8) @(posedge core_clk_in);
      op(2'b01, 16'h0001, RPL);
      op(2'b00, 16'h0003, RPL);
      p_rdy <= 1'b0;
      repeat (8) @(posedge core_clk_in);
      stat("not ready", ALM | CDN);
      p_rdy <= 1'b1;
      repeat (8) @(posedge core_clk_in);
      op(2'b01, 16'h0001, RPL);
      $display("test fault done");
      op(2'b01, 16'h0004, RPL);
      chk("irq set", {16'h0, ch.irq_lines}, 32'h1 << IL);
      op(2'b01, 16'h0002, RPL);
      chk("irq clear", {16'h0, ch.irq_lines}, 32'h0);
      chan(qw(2'b11), 16'h0000, 1'b1);
      chk("status two", rdv, 32'h0);
      apb(1'b0, 8'h10, 32'h0, rdv);
      chk("unmapped error", {31'h0, err_seen}, 32'h1);
      chan(qw(2'b01) | 16'h0020, 16'h0000, 1'b1);
      chk("unselected", rsp & 32'h7, 32'h1);
      reset_in <= 1'b1;
      repeat (16) @(posedge core_clk_in);
      reset_in <= 1'b0;
      repeat (8) @(posedge core_clk_in);
      stat("second reset", RDY);
      $display("test decode done");
      finish_test;
   end
endmodule : tb_card_punch_column_controller
`default_nettype wire
